// [src/lcrb_top.sv]
`timescale 1ns/1ps
// Contract
// - mode bit 4 low selects linear regulator, high selects load switch.
// - discharge bit 3 low never engages the discharge path when off.
// - discharge bit high and channel off switches the pull-down resistor on.
// - enable values 0 to 3 make the channel follow sequencer slot 0 to 3.
// - enable values 4 and 5 force the channel off over any slot.
// - enable values 6 and 7 force the channel on over any slot.
module lcrb_top (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       srst,
  // register port from the serial configuration interface
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_wr_data,
  input  wire logic       reg_rd_en,
  output logic      [7:0] reg_rd_data,
  output logic            reg_rd_valid,
  // power sequencer slot states
  input  wire logic [3:0] seq_slot_active,
  // channel controls to the analogue stage
  output logic            channel_enable,
  output logic            load_switch_mode,
  output logic            discharge_resistor
);

  logic [4:0]               regulator1_config_b;
  logic                     addr_hit;
  logic                     want_on;
  lcrb_pkg::lcrb_ch_state_t ch_state;
  lcrb_pkg::lcrb_ch_state_t next_ch_state;

  assign addr_hit = (reg_addr == lcrb_pkg::REG_ADDR);

  // register write; only the five defined bits are stored
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      regulator1_config_b <= lcrb_pkg::CFG_RESET;
    end else if (reg_wr_en && addr_hit) begin
      regulator1_config_b <= reg_wr_data[4:0];
    end
  end

  // register read; unmapped addresses answer zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rd_data  <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en && addr_hit) begin
        reg_rd_data <= {3'h0, regulator1_config_b};
      end else begin
        reg_rd_data <= 8'h00;
      end
    end
  end

  lcrb_enable_decode u_enable_decode (
    .enable_control (regulator1_config_b[lcrb_pkg::EN_MSB:lcrb_pkg::EN_LSB]),
    .slot_active    (seq_slot_active),
    .want_on        (want_on)
  );

  // channel power state
  always_comb begin
    case (ch_state)
      lcrb_pkg::LCRB_CH_OFF,
      lcrb_pkg::LCRB_CH_ON,
      lcrb_pkg::LCRB_CH_DISCHARGE: begin
        if (want_on) begin
          next_ch_state = lcrb_pkg::LCRB_CH_ON;
        end else if (regulator1_config_b[lcrb_pkg::DISCH_BIT]) begin
          next_ch_state = lcrb_pkg::LCRB_CH_DISCHARGE;
        end else begin
          next_ch_state = lcrb_pkg::LCRB_CH_OFF;
        end
      end
      default: begin
        next_ch_state = lcrb_pkg::LCRB_CH_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ch_state           <= lcrb_pkg::LCRB_CH_OFF;
      channel_enable     <= 1'b0;
      discharge_resistor <= 1'b0;
    end else begin
      ch_state           <= next_ch_state;
      channel_enable     <= (next_ch_state == lcrb_pkg::LCRB_CH_ON);
      discharge_resistor <= (next_ch_state == lcrb_pkg::LCRB_CH_DISCHARGE);
    end
  end

  // operating mode to the analogue stage
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      load_switch_mode <= lcrb_pkg::MODE_LINEAR;
    end else begin
      load_switch_mode <= regulator1_config_b[lcrb_pkg::MODE_BIT];
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  mode_follows_a: assert property (
    !$past(srst) |-> load_switch_mode == $past(regulator1_config_b[4]))
    else $error("load switch mode does not follow mode bit");

  no_discharge_a: assert property (
    !regulator1_config_b[3] |=> !discharge_resistor)
    else $error("discharge engaged while disabled");

  discharge_on_a: assert property (
    (regulator1_config_b[3] && !want_on) |=> discharge_resistor && !channel_enable)
    else $error("discharge resistor not engaged while off");

  slot_follow_a: assert property (
    !regulator1_config_b[2] |=> channel_enable == $past(seq_slot_active[regulator1_config_b[1:0]]))
    else $error("channel does not follow its sequencer slot");

  forced_off_a: assert property (
    regulator1_config_b[2:1] == 2'b10 |=> !channel_enable)
    else $error("channel on while forced off");

  forced_on_a: assert property (
    regulator1_config_b[2:1] == 2'b11 |=> channel_enable && !discharge_resistor)
    else $error("channel off while forced on");

  upper_zero_a: assert property (
    reg_rd_valid |-> reg_rd_data[7:5] == 3'h0)
    else $error("upper register bits read nonzero");

  write_read_a: assert property (
    (reg_wr_en && addr_hit && !reg_rd_en) ##1 (reg_rd_en && addr_hit && !reg_wr_en)
    |=> reg_rd_data == {3'h0, $past(reg_wr_data[4:0], 2)})
    else $error("read back differs from written value");

  exclusive_out_a: assert property (
    !(channel_enable && discharge_resistor))
    else $error("channel on with discharge engaged");

  // reset clears the outputs and the register, whatever was running
  reset_outputs_a: assert property (disable iff (1'b0)
    srst
    |=> !channel_enable && !discharge_resistor && !load_switch_mode && !reg_rd_valid)
    else $error("outputs not cleared by reset");

  reset_config_a: assert property (disable iff (1'b0)
    srst
    |=> regulator1_config_b == lcrb_pkg::CFG_RESET)
    else $error("register not cleared by reset");

  // register port
  write_lands_a: assert property (
    reg_wr_en && addr_hit
    |=> regulator1_config_b == $past(reg_wr_data[4:0]))
    else $error("accepted write not stored");

  foreign_write_a: assert property (
    reg_wr_en && !addr_hit
    |=> $stable(regulator1_config_b))
    else $error("write to another address changed the register");

  read_valid_a: assert property (
    reg_rd_en
    |=> reg_rd_valid)
    else $error("read not answered one cycle later");

  read_idle_a: assert property (
    !reg_rd_en
    |=> !reg_rd_valid && reg_rd_data == 8'h00)
    else $error("read answer without a read");

  foreign_read_a: assert property (
    reg_rd_en && !addr_hit
    |=> reg_rd_data == 8'h00)
    else $error("read of another address not zero");

  read_old_a: assert property (
    reg_rd_en && addr_hit
    |=> reg_rd_data == {3'h0, $past(regulator1_config_b)})
    else $error("read does not return the stored value");

  // channel state
  state_onehot_a: assert property (
    $onehot(ch_state))
    else $error("channel state not one-hot");

  state_outputs_a: assert property (
    channel_enable == (ch_state == lcrb_pkg::LCRB_CH_ON)
    && discharge_resistor == (ch_state == lcrb_pkg::LCRB_CH_DISCHARGE))
    else $error("channel outputs disagree with channel state");

  on_request_a: assert property (
    want_on
    |=> channel_enable && !discharge_resistor)
    else $error("channel not on while requested");

  off_request_a: assert property (
    !want_on
    |=> !channel_enable)
    else $error("channel on while not requested");

  slot_drop_a: assert property (
    !regulator1_config_b[2] && !seq_slot_active[regulator1_config_b[1:0]]
    |=> !channel_enable)
    else $error("channel on while its slot is down");

  mode_stable_a: assert property (
    $stable(regulator1_config_b[4])
    |=> $stable(load_switch_mode))
    else $error("load switch mode moved without a mode change");

  forced_on_c:     cover property (regulator1_config_b[2:1] == 2'b11 ##1 channel_enable);
  discharge_c:     cover property (channel_enable ##1 discharge_resistor);
  switch_mode_c:   cover property (load_switch_mode && channel_enable);
  slot_hand_c:     cover property (!regulator1_config_b[2] && $rose(channel_enable));
  foreign_write_c: cover property (reg_wr_en && !addr_hit);

endmodule : lcrb_top

// [src/lcrb_pkg.sv]
package lcrb_pkg;

  // register location and layout
  localparam logic [7:0] REG_ADDR         = 8'h4B;
  localparam int         MODE_BIT         = 4;
  localparam int         DISCH_BIT        = 3;
  localparam int         EN_MSB           = 2;
  localparam int         EN_LSB           = 0;
  localparam int         CFG_WIDTH        = 5;
  localparam int         DATA_WIDTH       = 8;
  localparam int         SLOT_COUNT       = 4;

  // value after reset; the factory-programmed source is not modelled
  localparam logic [4:0] CFG_RESET        = 5'h00;

  // enable control encodings
  localparam logic [2:0] EN_SLOT0         = 3'h0;
  localparam logic [2:0] EN_SLOT3         = 3'h3;
  localparam logic [2:0] EN_FORCE_OFF_A   = 3'h4;
  localparam logic [2:0] EN_FORCE_OFF_B   = 3'h5;
  localparam logic [2:0] EN_FORCE_ON_A    = 3'h6;
  localparam logic [2:0] EN_FORCE_ON_B    = 3'h7;

  // mode bit values
  localparam logic       MODE_LINEAR      = 1'b0;
  localparam logic       MODE_LOAD_SWITCH = 1'b1;

  // channel power state
  typedef enum logic [2:0] {
    LCRB_CH_OFF       = 3'b001,
    LCRB_CH_ON        = 3'b010,
    LCRB_CH_DISCHARGE = 3'b100
  } lcrb_ch_state_t;

endpackage : lcrb_pkg

// [src/lcrb_enable_decode.sv]
`timescale 1ns/1ps
module lcrb_enable_decode (
  // enable control field
  input  wire logic [2:0] enable_control,
  // sequencer slot states, one bit per slot
  input  wire logic [3:0] slot_active,
  // wanted channel state
  output logic            want_on
);

  always_comb begin
    case (enable_control)
      lcrb_pkg::EN_FORCE_OFF_A,
      lcrb_pkg::EN_FORCE_OFF_B: begin
        want_on = 1'b0;
      end
      lcrb_pkg::EN_FORCE_ON_A,
      lcrb_pkg::EN_FORCE_ON_B: begin
        want_on = 1'b1;
      end
      default: begin
        want_on = slot_active[enable_control[1:0]];
      end
    endcase
  end

endmodule : lcrb_enable_decode

// [test/lcrb_tb_top.sv]
`timescale 1ns/1ps
module lcrb_tb_top;
  logic       clk_sys;
  logic       srst;
  logic [7:0] reg_addr;
  logic       reg_wr_en;
  logic [7:0] reg_wr_data;
  logic       reg_rd_en;
  logic [7:0] reg_rd_data;
  logic       reg_rd_valid;
  logic [3:0] seq_slot_active;
  logic       channel_enable;
  logic       load_switch_mode;
  logic       discharge_resistor;
  logic       exp_on;
  int         n_errors;
  int         n_compared;

  lcrb_top u_dut (
    .clk_sys            (clk_sys),
    .srst               (srst),
    .reg_addr           (reg_addr),
    .reg_wr_en          (reg_wr_en),
    .reg_wr_data        (reg_wr_data),
    .reg_rd_en          (reg_rd_en),
    .reg_rd_data        (reg_rd_data),
    .reg_rd_valid       (reg_rd_valid),
    .seq_slot_active    (seq_slot_active),
    .channel_enable     (channel_enable),
    .load_switch_mode   (load_switch_mode),
    .discharge_resistor (discharge_resistor)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // outputs follow the new config two edges after the strobe
  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_sys) #1;
    reg_addr    = addr;
    reg_wr_data = data;
    reg_wr_en   = 1'b1;
    @(posedge clk_sys) #1;
    reg_wr_en = 1'b0;
    @(posedge clk_sys) #1;
  endtask : reg_write

  task automatic read_chk(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clk_sys) #1;
    reg_addr  = addr;
    reg_rd_en = 1'b1;
    @(posedge clk_sys) #1;
    reg_rd_en = 1'b0;
    chk({reg_rd_valid, reg_rd_data}, {1'b1, exp});
  endtask : read_chk

  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  initial begin
    srst = 1'b1;
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
    seq_slot_active = 4'h0;
    n_errors = 0;
    n_compared = 0;
    repeat (8) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    chk({6'h00, channel_enable, load_switch_mode, discharge_resistor}, 9'h000);
    read_chk(lcrb_pkg::REG_ADDR, 8'h00);
    $display("test reset done");
    reg_write(lcrb_pkg::REG_ADDR, 8'hFF);
    read_chk(lcrb_pkg::REG_ADDR, 8'h1F);
    chk({6'h00, channel_enable, load_switch_mode, discharge_resistor}, 9'h006);
    reg_write(lcrb_pkg::REG_ADDR, 8'hEF);
    chk({8'h00, load_switch_mode}, 9'h000);
    reg_write(8'h4A, 8'h00);
    read_chk(lcrb_pkg::REG_ADDR, 8'h0F);
    read_chk(8'h4A, 8'h00);
    // write then read on consecutive edges, then write and read on one edge
    @(posedge clk_sys) #1;
    reg_addr    = lcrb_pkg::REG_ADDR;
    reg_wr_data = 8'h1A;
    reg_wr_en   = 1'b1;
    @(posedge clk_sys) #1;
    reg_wr_en   = 1'b0;
    reg_rd_en   = 1'b1;
    @(posedge clk_sys) #1;
    chk({reg_rd_valid, reg_rd_data}, 9'h11A);
    reg_wr_data = 8'h03;
    reg_wr_en   = 1'b1;
    @(posedge clk_sys) #1;
    reg_wr_en   = 1'b0;
    reg_rd_en   = 1'b0;
    chk({reg_rd_valid, reg_rd_data}, 9'h11A);
    read_chk(lcrb_pkg::REG_ADDR, 8'h03);
    $display("test access done");
    // every enable code, its own slot down then up
    for (int e = 0; e < 8; e++) begin
      for (int s = 0; s < 2; s++) begin
        reg_write(lcrb_pkg::REG_ADDR, 8'h08 | 8'(e));
        seq_slot_active = (s == 1) ? (4'h1 << e[1:0]) : ~(4'h1 << e[1:0]);
        @(posedge clk_sys) #1;
        exp_on = (e < 4) ? (s == 1) : (e >= 6);
        chk({7'h00, channel_enable, discharge_resistor}, {7'h00, exp_on, !exp_on});
      end
    end
    $display("test enable decode done");
    reg_write(lcrb_pkg::REG_ADDR, 8'h04);
    chk({7'h00, channel_enable, discharge_resistor}, 9'h000);
    $display("test no discharge done");
    // reset in mid-run with the channel forced on in load switch mode
    reg_write(lcrb_pkg::REG_ADDR, 8'h1E);
    chk({6'h00, channel_enable, load_switch_mode, discharge_resistor}, 9'h006);
    @(posedge clk_sys) #1;
    srst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    chk({6'h00, channel_enable, load_switch_mode, discharge_resistor}, 9'h000);
    read_chk(lcrb_pkg::REG_ADDR, 8'h00);
    $display("test mid reset done");
    end_sim();
  end
endmodule : lcrb_tb_top
